// ==== rtl/scl_loader.sv ====
// scl_loader: serial control word loader with parallel phase/attenuation and port routing.
// assumes pins arrive asynchronously and the shift clock is well below clk_i / 2.
`timescale 1ns/100ps
`default_nettype none

module scl_loader
   import scl_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [DATA_W-1:0] avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic      [DATA_W-1:0] avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire logic              sdata_i,
   input  wire logic              sclk_i,
   input  wire logic              latch_strobe_i,
   input  wire logic              port_select_i,
   output logic      [FIELD_W-1:0] phase_o,
   output logic      [FIELD_W-1:0] atten_o,
   output logic                   path13_o,
   output logic                   path23_o,
   output logic                   term1_o,
   output logic                   term2_o,
   output logic                   sdata_o
);

   // pin synchronisers; all four pins share one two-flop stage
   logic [3:0] pins_s;

   scl_sync #(
      .W (4)
   ) u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .d_i     ({port_select_i, latch_strobe_i, sclk_i, sdata_i}),
      .q_o     (pins_s)
   );

   wire sdata_s = pins_s[0];
   wire sclk_s  = pins_s[1];
   wire le_s    = pins_s[2];
   wire psel_s  = pins_s[3];

   logic [WORD_W-1:0]   shift_r;
   logic [WORD_W-1:0]   shadow_r;
   scl_word_s           word_r;
   logic                pend_r;
   logic [BITCNT_W-1:0] bitcnt_r;
   logic                lerr_r;
   logic [COUNT_W-1:0]  xfer_cnt_r;
   logic [CTRL_W-1:0]   ctrl_r;
   scl_route_s          route_r;
   logic                sclk_d_r;
   logic                le_d_r;
   logic                sdata_o_r;
   logic                resp_r;
   logic [DATA_W-1:0]   rdata_r;

   // edge detection on synchronised copies; disabled loader ignores the link
   wire loader_en = ctrl_r[CTRL_EN_BIT];
   wire sclk_rise = loader_en & sclk_s & ~sclk_d_r;
   wire le_rise   = loader_en & le_s & ~le_d_r;
   wire load_word = sclk_rise & pend_r;

   wire [WORD_W-1:0]   shift_nxt  = {sdata_s, shift_r[WORD_W-1:1]};
   wire [WORD_W-1:0]   shadow_nxt = le_rise ? shift_r : shadow_r;
   wire                pend_nxt   = le_rise ? 1'b1 : (sclk_rise ? 1'b0 : pend_r);
   wire                bit_sat    = (bitcnt_r == BITCNT_MAX);
   wire [BITCNT_W-1:0] bitcnt_inc = bit_sat ? bitcnt_r : bitcnt_r + 4'h1;
   wire [BITCNT_W-1:0] bitcnt_nxt = le_rise ? 4'h0 : (sclk_rise ? bitcnt_inc : bitcnt_r);

   // port select: software override has priority over the pin
   wire        sel_eff   = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_SEL_BIT] : psel_s;
   scl_route_s route_nxt;
   assign route_nxt = scl_route(sel_eff);

   // Avalon-MM: one wait cycle, then the access completes
   wire access   = avs_read_i | avs_write_i;
   wire wr_go    = avs_write_i & resp_r;
   wire rd_first = avs_read_i & ~resp_r;

   wire hit_word   = (avs_address_i == OFF_WORD);
   wire hit_shift  = (avs_address_i == OFF_SHIFT);
   wire hit_ctrl   = (avs_address_i == OFF_CTRL);
   wire hit_status = (avs_address_i == OFF_STATUS);
   wire hit_count  = (avs_address_i == OFF_COUNT);
   wire hit_phase  = (avs_address_i == OFF_PHASE);
   wire hit_atten  = (avs_address_i == OFF_ATTEN);

   wire wr_ctrl   = wr_go & hit_ctrl & avs_byteenable_i[0];
   wire clr_lerr  = wr_go & hit_status & avs_byteenable_i[0]
                    & avs_writedata_i[STAT_LERR_BIT];
   wire set_lerr  = le_rise & (bitcnt_r != BITS_PER_WORD);
   // a short or long word seen in the clearing cycle still sets the flag
   wire lerr_nxt  = set_lerr | (lerr_r & ~clr_lerr);

   wire [CTRL_W-1:0] ctrl_nxt = wr_ctrl ? avs_writedata_i[CTRL_W-1:0] : ctrl_r;

   wire [DATA_W-1:0] status_val = {{(DATA_W-STAT_BCNT_LSB-BITCNT_W){1'b0}}, bitcnt_r,
                                   1'b0, lerr_r, route_r.path13, pend_r};

   wire [DATA_W-1:0] rd_mux =
      hit_word   ? {{(DATA_W-WORD_W){1'b0}}, word_r}          :
      hit_shift  ? {{(DATA_W-WORD_W){1'b0}}, shift_r}         :
      hit_ctrl   ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_r}          :
      hit_status ? status_val                                 :
      hit_count  ? {{(DATA_W-COUNT_W){1'b0}}, xfer_cnt_r}     :
      hit_phase  ? scl_phase_mdeg(word_r.phase)               :
      hit_atten  ? scl_atten_cdb(word_r.atten)                :
                   32'h0000_0000;

   // link-facing state
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sclk_d_r <= 1'b0;
         le_d_r   <= 1'b0;
         shift_r  <= WORD_RESET;
         shadow_r <= WORD_RESET;
         pend_r   <= 1'b0;
         bitcnt_r <= 4'h0;
      end else begin
         sclk_d_r <= sclk_s;
         le_d_r   <= le_s;
         if (sclk_rise) begin
            shift_r <= shift_nxt;
         end
         shadow_r <= shadow_nxt;
         pend_r   <= pend_nxt;
         bitcnt_r <= bitcnt_nxt;
      end
   end

   // parallel word only moves on the shift edge after a strobe
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         word_r     <= WORD_RESET;
         xfer_cnt_r <= 16'h0000;
         sdata_o_r  <= 1'b0;
      end else begin
         if (load_word) begin
            word_r     <= shadow_r;
            xfer_cnt_r <= xfer_cnt_r + 16'h0001;
         end
         if (sclk_rise) begin
            sdata_o_r <= shift_r[0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         route_r <= scl_route(1'b0);
      end else begin
         route_r <= route_nxt;
      end
   end

   // register file and bus handshake
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctrl_r  <= CTRL_RESET;
         lerr_r  <= 1'b0;
         resp_r  <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ctrl_r <= ctrl_nxt;
         lerr_r <= lerr_nxt;
         resp_r <= access & ~resp_r;
         if (rd_first) begin
            rdata_r <= rd_mux;
         end
      end
   end

   assign avs_waitrequest_o = access & ~resp_r;
   assign avs_readdata_o    = rdata_r;
   assign phase_o           = word_r.phase;
   assign atten_o           = word_r.atten;
   assign path13_o          = route_r.path13;
   assign path23_o          = route_r.path23;
   assign term1_o           = route_r.term1;
   assign term2_o           = route_r.term2;
   assign sdata_o           = sdata_o_r;

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   AST_SHIFT_CAPTURE: assert property (
      sclk_rise |=> (shift_r[WORD_W-1] == $past(sdata_s))
                    && (shift_r[WORD_W-2:0] == $past(shift_r[WORD_W-1:1])))
      else $error("serial bit not captured on shift edge");

   AST_SHIFT_RETAIN: assert property (
      !sclk_rise |=> $stable(shift_r))
      else $error("shift register changed without a shift edge");

   AST_WORD_HOLD: assert property (
      !load_word |=> $stable(word_r))
      else $error("parallel word changed without a strobe transfer");

   AST_STROBE_ARMS: assert property (
      le_rise |=> pend_r && (shadow_r == $past(shift_r)))
      else $error("strobe did not arm the transfer");

   // first shift edge after an armed strobe, however long the gap
   AST_LOAD_ON_EDGE: assert property (
      (sclk_rise && pend_r && !le_rise) |=> (word_r == $past(shadow_r)) && !pend_r)
      else $error("word not transferred at first shift edge after strobe");

   AST_FIELD_SPLIT: assert property (
      load_word |=> (phase_o == $past(shadow_r[FIELD_W-1:0]))
                    && (atten_o == $past(shadow_r[WORD_W-1:FIELD_W])))
      else $error("latched bits not split into phase and attenuation");

   AST_PHASE_WEIGHT: assert property (
      (avs_read_i && hit_phase && !avs_waitrequest_o)
      |-> avs_readdata_o == scl_phase_mdeg($past(phase_o)))
      else $error("phase weight readback wrong");

   AST_ATTEN_WEIGHT: assert property (
      (avs_read_i && hit_atten && !avs_waitrequest_o)
      |-> avs_readdata_o == scl_atten_cdb($past(atten_o)))
      else $error("attenuation weight readback wrong");

   AST_ROUTE_HIGH: assert property (
      (!ctrl_r[CTRL_OVR_BIT] && psel_s)
      |=> path13_o && !path23_o && term2_o && !term1_o)
      else $error("port 1 path not selected with select high");

   AST_ROUTE_LOW: assert property (
      (!ctrl_r[CTRL_OVR_BIT] && !psel_s)
      |=> path23_o && !path13_o && term1_o && !term2_o)
      else $error("port 2 path not selected with select low");

   AST_LERR_SET: assert property (
      (le_rise && bitcnt_r != BITS_PER_WORD) |=> lerr_r)
      else $error("word length error not flagged");

   AST_BUS_ANSWER: assert property (
      (access && avs_waitrequest_o) |=> !avs_waitrequest_o)
      else $error("bus access not answered after one wait cycle");

   AST_SDATA_OUT: assert property (
      sclk_rise |=> (sdata_o == $past(shift_r[0])))
      else $error("shifted-out bit does not follow the shift register");

   AST_SHADOW_HOLD: assert property (
      !le_rise |=> $stable(shadow_r))
      else $error("shadow word changed without a strobe");

   AST_DISABLED_IGNORE: assert property (
      !loader_en |=> $stable(shift_r) && $stable(shadow_r)
                     && $stable(word_r) && $stable(pend_r))
      else $error("disabled loader reacted to the link");

   AST_COUNT_STEP: assert property (
      load_word |=> (xfer_cnt_r == $past(xfer_cnt_r) + 16'h0001))
      else $error("transfer count did not step on a transfer");

   AST_COUNT_HOLD: assert property (
      !load_word |=> $stable(xfer_cnt_r))
      else $error("transfer count moved without a transfer");

   AST_BITCNT_CLEAR: assert property (
      le_rise |=> (bitcnt_r == 4'h0))
      else $error("bit count not cleared by the strobe");

   AST_BITCNT_SAT: assert property (
      (bit_sat && !le_rise) |=> bit_sat)
      else $error("saturated bit count wrapped");

   AST_LERR_STICKY: assert property (
      (lerr_r && !clr_lerr) |=> lerr_r)
      else $error("length error cleared without a write");

   AST_LERR_CLEAR: assert property (
      (clr_lerr && !set_lerr) |=> !lerr_r)
      else $error("length error not cleared by a write of one");

   AST_CTRL_WRITE: assert property (
      wr_ctrl |=> (ctrl_r == $past(avs_writedata_i[CTRL_W-1:0])))
      else $error("control write did not land");

   AST_READ_HOLD: assert property (
      !rd_first |=> $stable(avs_readdata_o))
      else $error("read data moved outside a read");

   AST_ROUTE_EXCL: assert property (
      (path13_o ^ path23_o) && (term1_o == path23_o) && (term2_o == path13_o))
      else $error("port paths and terminations disagree");

   COV_TRANSFER:  cover property (le_rise ##[1:40] load_word);
   COV_FULL_WORD: cover property (le_rise && bitcnt_r == BITS_PER_WORD);
   COV_LERR:      cover property (set_lerr);
   COV_OVERRIDE:  cover property (ctrl_r[CTRL_OVR_BIT] && (ctrl_r[CTRL_SEL_BIT] != psel_s));
   COV_TWO_LOADS: cover property (load_word ##[1:300] load_word);

endmodule

`default_nettype wire

// ==== rtl/scl_pkg.sv ====
// scl_pkg: constants, types and helpers for the serial control word loader.
// assumes a single 20 MHz system clock and an Avalon-MM slave with 32-bit data.

package scl_pkg;

   localparam int WORD_W   = 12;
   localparam int FIELD_W  = 6;
   localparam int BITCNT_W = 4;
   localparam int COUNT_W  = 16;
   localparam int ADDR_W   = 5;
   localparam int DATA_W   = 32;

   localparam logic [BITCNT_W-1:0] BITS_PER_WORD = 4'hC;
   localparam logic [BITCNT_W-1:0] BITCNT_MAX    = 4'hF;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_WORD   = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_SHIFT  = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_COUNT  = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_PHASE  = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_ATTEN  = 5'h18;

   // control fields
   localparam int CTRL_W        = 3;
   localparam int CTRL_EN_BIT   = 0;
   localparam int CTRL_OVR_BIT  = 1;
   localparam int CTRL_SEL_BIT  = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h1;

   // status fields
   localparam int STAT_PEND_BIT  = 0;
   localparam int STAT_SEL_BIT   = 1;
   localparam int STAT_LERR_BIT  = 2;
   localparam int STAT_BCNT_LSB  = 4;

   localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;

   // bit weights: phase in millidegrees, attenuation in centi-dB
   localparam logic [DATA_W-1:0] PHASE_LSB_MDEG = 32'h0000_15F9;
   localparam logic [DATA_W-1:0] ATTEN_LSB_CDB  = 32'h0000_0032;

   // timing: system clock against the fastest allowed serial rate
   localparam int CLK_FREQ_MHZ    = 20;
   localparam int SERIAL_MAX_MHZ  = 100;

   typedef struct packed {
      logic [FIELD_W-1:0] atten;
      logic [FIELD_W-1:0] phase;
   } scl_word_s;

   typedef struct packed {
      logic path13;
      logic path23;
      logic term1;
      logic term2;
   } scl_route_s;

   function automatic logic [DATA_W-1:0] scl_phase_mdeg(input logic [FIELD_W-1:0] code);
      return DATA_W'(code) * PHASE_LSB_MDEG;
   endfunction

   function automatic logic [DATA_W-1:0] scl_atten_cdb(input logic [FIELD_W-1:0] code);
      return DATA_W'(code) * ATTEN_LSB_CDB;
   endfunction

   function automatic scl_route_s scl_route(input logic sel);
      scl_route_s r;
      r.path13 = sel;
      r.path23 = ~sel;
      r.term1  = ~sel;
      r.term2  = sel;
      return r;
   endfunction

endpackage

// ==== rtl/scl_sync.sv ====
// scl_sync: two flip-flop synchroniser for asynchronous pin levels.
// assumes the destination clock is clk_i; only the second stage is visible.
`timescale 1ns/100ps
`default_nettype none

module scl_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= d_i;
         q_r    <= meta_r;
      end
   end

   assign q_o = q_r;

endmodule

`default_nettype wire

// ==== verif/scl_ctrl_model.sv ====
// scl_ctrl_model: serial controller model driving data, shift clock and strobe.
// assumes start_i pulses one cycle, with word and options held until done_o.
`timescale 1ns/100ps
`default_nettype none

module scl_ctrl_model (
   input  wire logic        clk_i,
   input  wire logic        start_i,
   input  wire logic [11:0] word_i,
   input  wire logic [3:0]  nbits_i,
   input  wire logic        strobe_i,
   input  wire logic        xfer_i,
   output logic             sdata_o,
   output logic             sclk_o,
   output logic             latch_strobe_o,
   output logic             done_o
);
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // 3 cycles per phase: the loader samples, so the nominal rate is out of reach
   task automatic pulse_clk();
      hold(3);
      sclk_o <= 1'b1;
      hold(3);
      sclk_o <= 1'b0;
   endtask

   initial begin
      {sdata_o, sclk_o, latch_strobe_o, done_o} = 4'h1;
      forever begin
         @(posedge clk_i);
         if (start_i) begin
            done_o <= 1'b0;
            for (int i = 0; i < nbits_i; i++) begin
               sdata_o <= word_i[i];
               pulse_clk();
            end
            if (strobe_i) begin
               hold(3);
               latch_strobe_o <= 1'b1;
               hold(3);
               latch_strobe_o <= 1'b0;
            end
            if (xfer_i) begin
               sdata_o <= ~sdata_o;
               pulse_clk();
            end
            hold(3);
            done_o <= 1'b1;
         end else begin
            // idle data toggles so a stale bit never looks valid
            sdata_o <= ~sdata_o;
         end
      end
   end
endmodule

`default_nettype wire

// ==== verif/scl_loader_tb.sv ====
// scl_loader_tb: self-checking bench for the serial control word loader.
// assumes the controller model on the pins and an Avalon master task here.
`timescale 1ns/100ps
`default_nettype none

module scl_loader_tb
   import scl_pkg::*;
();
   logic              clk_i, reset_i, rd_i, wr_i, start, strobe_en, xfer, port_sel;
   logic              sdata, sclk, strobe, done, wait_o, dout;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata_o, rd;
   logic [3:0]        be, nbits;
   logic [11:0]       word;
   logic [5:0]        phase_o, atten_o;
   logic              p13, p23, t1, t2;
   int                err_total, num_checks, cycles;

   scl_loader uut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(addr),
      .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata_o), .avs_waitrequest_o(wait_o),
      .sdata_i(sdata), .sclk_i(sclk), .latch_strobe_i(strobe),
      .port_select_i(port_sel), .phase_o(phase_o), .atten_o(atten_o),
      .path13_o(p13), .path23_o(p23), .term1_o(t1), .term2_o(t2), .sdata_o(dout));

   scl_ctrl_model ctl (.clk_i(clk_i), .start_i(start), .word_i(word), .nbits_i(nbits),
      .strobe_i(strobe_en), .xfer_i(xfer), .sdata_o(sdata), .sclk_o(sclk),
      .latch_strobe_o(strobe), .done_o(done));

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= wd;
      rd_i <= ~w;
      wr_i <= w;
      // wait until waitrequest drops; no limit but the bench timeout
      do begin
         @(posedge clk_i);
      end while (wait_o !== 1'b0);
      d = rdata_o;
      rd_i <= 1'b0;
      wr_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      chk(d, e);
   endtask

   task automatic frame(input logic [11:0] w, input logic [3:0] n, input logic s,
                        input logic x);
      @(posedge clk_i);
      {word, nbits, strobe_en, xfer, start} <= {w, n, s, x, 1'b1};
      @(posedge clk_i);
      start <= 1'b0;
      do begin
         @(posedge clk_i);
      end while (done !== 1'b1);
      @(negedge clk_i);
   endtask

   task automatic t_reset();
      @(negedge clk_i);
      chk(32'({atten_o, phase_o}), 32'h0);
      chk(32'({p13, p23, t1, t2}), 32'h6);
      rd_chk(OFF_CTRL, 32'h1);
      rd_chk(5'h1C, 32'h0);
   endtask

   task automatic t_load();
      logic [11:0] w [2] = '{12'hABC, 12'h821};
      for (int i = 0; i < 2; i++) begin
         frame(w[i], 4'hC, 1'b1, 1'b1);
         chk(32'(phase_o), 32'(w[i][5:0]));
         chk(32'(atten_o), 32'(w[i][11:6]));
         rd_chk(OFF_WORD, 32'(w[i]));
         chk(32'(dout), 32'(w[i][0]));
         rd_chk(OFF_PHASE, 32'(w[i][5:0]) * 32'h15F9);
         rd_chk(OFF_ATTEN, 32'(w[i][11:6]) * 32'h32);
      end
   endtask

   task automatic t_hold();
      frame(12'h5A3, 4'hC, 1'b1, 1'b0);
      chk(32'({atten_o, phase_o}), 32'h821);
      rd_chk(OFF_SHIFT, 32'h5A3);
      bus(1'b0, OFF_STATUS, 32'h0, rd);
      chk(rd & 32'h1, 32'h1);
      frame(12'h000, 4'h0, 1'b0, 1'b1);
      chk(32'({atten_o, phase_o}), 32'h5A3);
      rd_chk(OFF_COUNT, 32'h3);
   endtask

   task automatic t_disable();
      bus(1'b1, OFF_CTRL, 32'h0, rd);
      frame(12'h111, 4'hC, 1'b1, 1'b1);
      chk(32'({atten_o, phase_o}), 32'h5A3);
      rd_chk(OFF_CTRL, 32'h0);
      bus(1'b1, OFF_CTRL, 32'h1, rd);
   endtask

   // ten bits: wrong whether or not the transfer edge is counted
   task automatic t_lenerr();
      bus(1'b1, OFF_STATUS, 32'h4, rd);
      frame(12'hFFF, 4'hA, 1'b1, 1'b1);
      bus(1'b0, OFF_STATUS, 32'h0, rd);
      chk(rd & 32'h4, 32'h4);
      bus(1'b1, OFF_STATUS, 32'h4, rd);
      bus(1'b0, OFF_STATUS, 32'h0, rd);
      chk(rd & 32'h4, 32'h0);
   endtask

   task automatic t_route();
      @(posedge clk_i);
      port_sel <= 1'b1;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk(32'({p13, p23, t1, t2}), 32'h9);
      bus(1'b0, OFF_STATUS, 32'h0, rd);
      chk(rd & 32'h2, 32'h2);
      // software override low beats the high pin
      bus(1'b1, OFF_CTRL, 32'h3, rd);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk(32'({p13, p23, t1, t2}), 32'h6);
      bus(1'b1, OFF_CTRL, 32'h1, rd);
      @(posedge clk_i);
      port_sel <= 1'b0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk(32'({p13, p23, t1, t2}), 32'h6);
      bus(1'b1, OFF_CTRL, 32'h7, rd);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk(32'({p13, p23, t1, t2}), 32'h9);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 8000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      {reset_i, rd_i, wr_i, start, strobe_en, xfer, port_sel} = 7'h40;
      {addr, wdata, word, nbits, be} = '0;
      {err_total, num_checks, cycles} = '0;
      be = 4'hF;
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_load();
      t_hold();
      t_disable();
      t_lenerr();
      t_route();
      // second reset with the override set and a word loaded
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset();
      complete_run();
   end
endmodule

`default_nettype wire
